// ===== design/ioc_defines.svh
`ifndef IOC_DEFINES_SVH
`define IOC_DEFINES_SVH

// Synchroniser lanes, one per signal that arrives from outside the domain
`define IOC_SYNC_W        5
`define IOC_SB_PAD        0
`define IOC_SB_INPUT_CLOCK_FIRST      1
`define IOC_SB_INPUT_CLOCK_SECOND      2
`define IOC_SB_OCLK1      3
`define IOC_SB_OCLK2      4

// Reset values
`define IOC_RST_SYNC      5'h00
`define IOC_RST_CAPTURE   1'b0
`define IOC_RST_PAD       1'b0
`define IOC_RST_PAD_OE    1'b0
`define IOC_RST_SEL       1'b0

`endif

// ===== design/ioc_pkg.sv
package ioc_pkg;

  typedef enum logic [1:0] {
    IOC_OUT_DIRECT,
    IOC_OUT_LATCH,
    IOC_OUT_SDR,
    IOC_OUT_DDR
  } ioc_out_mode_e;

  typedef struct packed {
    ioc_out_mode_e out_mode;
    logic          sr_async;
    logic          sr_set;
    logic          in_ddr;
  } ioc_cfg_s;

endpackage : ioc_pkg

// ===== design/ioc_sync.sv
`timescale 1ns/10ps
`include "ioc_defines.svh"

module ioc_sync
  import ioc_pkg::*;
(
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset_n,
  input  wire logic [`IOC_SYNC_W-1:0]   i_async,
  output logic      [`IOC_SYNC_W-1:0]   o_sync
);

  logic [`IOC_SYNC_W-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < `IOC_SYNC_W; g = g + 1) begin : g_lane
      // Only the second stage is visible to the rest of the block
      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          meta[g]   <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta[g]   <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule : ioc_sync

// ===== design/ioc_io_cell.sv
// Contract
// RULE1: One shared input enable gates both capture registers.
// RULE2: The same pad line feeds both capture registers.
// RULE3: Capture one samples the pad on each first input clock rise.
// RULE4: Capture two samples the pad on each second input clock rise.
// RULE5: Sync set/reset clears each capture register at its own clock rise.
// RULE6: Fabric moves the input enable only between the two clock rises.
// RULE7: The pad is driven directly, via a latch, or from a register.
// RULE8: The output register loads only while its enable is high.
// RULE9: Sync set/reset resets the output register at its next edge.
// RULE10: Async set/reset forces the output register at once, clock or not.
// RULE11: Global set/reset forces the output register to its set value.
// RULE12: Fabric moves the output enable only between the two clock rises.
// RULE13: DDR output register one loads data one on output clock one rise.
// RULE14: DDR output register two loads data two on output clock two rise.
// RULE15: Sync set/reset in DDR mode clears each output register in turn.
// RULE16: The single-rate capture takes the pad on its clock while enabled.
// RULE17: In DDR mode the pad shows the output register clocked last.
`timescale 1ns/10ps
`include "ioc_defines.svh"

module ioc_io_cell
  import ioc_pkg::*;
(
  input  wire logic     i_clk_sys,
  input  wire logic     i_reset_n,
  input  wire ioc_cfg_s i_cfg,
  input  wire logic     i_pad,
  output logic          o_pad,
  output logic          o_pad_oe,
  input  wire logic     i_input_clock_first,
  input  wire logic     i_input_clock_second,
  input  wire logic     i_input_clock_enable,
  output logic          o_input_capture_first,
  output logic          o_input_capture_second,
  output logic          o_input_capture_out,
  input  wire logic     i_output_clock_first,
  input  wire logic     i_output_clock_second,
  input  wire logic     i_output_clock_enable,
  input  wire logic     i_output_data_first,
  input  wire logic     i_output_data_second,
  input  wire logic     i_local_set_reset,
  input  wire logic     i_global_set_reset
);

  // ------------------------------------------------------------------
  // Pin-side inputs pass the synchroniser before anything looks at them
  // ------------------------------------------------------------------
  logic [`IOC_SYNC_W-1:0] raw_async;
  logic [`IOC_SYNC_W-1:0] synced;
  logic [`IOC_SYNC_W-1:0] synced_prev;
  logic [`IOC_SYNC_W-1:0] next_synced_prev;

  always_comb begin
    raw_async                  = '0;
    raw_async[`IOC_SB_PAD]     = i_pad;
    raw_async[`IOC_SB_INPUT_CLOCK_FIRST]   = i_input_clock_first;
    raw_async[`IOC_SB_INPUT_CLOCK_SECOND]   = i_input_clock_second;
    raw_async[`IOC_SB_OCLK1]   = i_output_clock_first;
    raw_async[`IOC_SB_OCLK2]   = i_output_clock_second;
  end

  ioc_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   (raw_async),
    .o_sync    (synced)
  );

  always_comb begin
    next_synced_prev = synced;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      synced_prev <= `IOC_RST_SYNC;
    end else begin
      synced_prev <= next_synced_prev;
    end
  end

  logic pad_s;
  logic rise_i1;
  logic rise_i2;
  logic rise_o1;
  logic rise_o2;
  logic latch_gate;

  assign pad_s      = synced[`IOC_SB_PAD];
  assign rise_i1    = synced[`IOC_SB_INPUT_CLOCK_FIRST] & ~synced_prev[`IOC_SB_INPUT_CLOCK_FIRST];
  assign rise_i2    = synced[`IOC_SB_INPUT_CLOCK_SECOND] & ~synced_prev[`IOC_SB_INPUT_CLOCK_SECOND];
  assign rise_o1    = synced[`IOC_SB_OCLK1] & ~synced_prev[`IOC_SB_OCLK1];
  assign rise_o2    = synced[`IOC_SB_OCLK2] & ~synced_prev[`IOC_SB_OCLK2];
  // Latch is open while the first output clock is high
  assign latch_gate = synced[`IOC_SB_OCLK1];

  // ------------------------------------------------------------------
  // Set/reset decoding shared by the input and output sides
  // ------------------------------------------------------------------
  logic force_now;
  logic sr_sync;
  logic sr_value;

  // Global and asynchronous local set/reset both act without an edge
  assign force_now = i_global_set_reset                             // RULE11
                   | (i_cfg.sr_async & i_local_set_reset);         // RULE10
  assign sr_sync   = ~i_cfg.sr_async & i_local_set_reset;
  assign sr_value  = i_cfg.sr_set;

  // ------------------------------------------------------------------
  // Input capture registers
  // ------------------------------------------------------------------
  logic cap_first;
  logic cap_second;
  logic next_cap_first;
  logic next_cap_second;

  // Enable and pad are common to both; fabric must keep them still
  // across both clock rises (RULE6), otherwise the pair disagrees
  always_comb begin
    next_cap_first  = cap_first;
    next_cap_second = cap_second;
    if (force_now) begin
      next_cap_first  = sr_value;
      next_cap_second = sr_value;
    end else begin
      if (rise_i1) begin
        if (sr_sync) begin
          next_cap_first = sr_value;                               // RULE5
        end else if (i_input_clock_enable) begin                   // RULE1
          next_cap_first = pad_s;                                  // RULE3
        end
      end
      if (rise_i2 && i_cfg.in_ddr) begin
        if (sr_sync) begin
          next_cap_second = sr_value;                              // RULE5
        end else if (i_input_clock_enable) begin                   // RULE1
          next_cap_second = pad_s;                                 // RULE2 RULE4
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_first  <= `IOC_RST_CAPTURE;
      cap_second <= `IOC_RST_CAPTURE;
    end else begin
      cap_first  <= next_cap_first;
      cap_second <= next_cap_second;
    end
  end

  assign o_input_capture_first  = cap_first;
  assign o_input_capture_second = cap_second;
  // Single-rate capture is the first register used alone
  assign o_input_capture_out    = cap_first;                       // RULE16

  // ------------------------------------------------------------------
  // Output registers, latch and last-clocked selector
  // ------------------------------------------------------------------
  logic oreg_first;
  logic oreg_second;
  logic olatch;
  logic last_second;
  logic next_oreg_first;
  logic next_oreg_second;
  logic next_olatch;
  logic next_last_second;
  logic is_ddr;

  assign is_ddr = (i_cfg.out_mode == IOC_OUT_DDR);

  always_comb begin
    next_oreg_first  = oreg_first;
    next_oreg_second = oreg_second;
    next_olatch      = olatch;
    next_last_second = last_second;
    if (force_now) begin
      next_oreg_first  = sr_value;                                 // RULE10 RULE11
      next_oreg_second = sr_value;
      next_olatch      = sr_value;
    end else begin
      if (latch_gate) begin
        next_olatch = i_output_data_first;                         // RULE7
      end
      if (rise_o1) begin
        if (sr_sync) begin
          next_oreg_first = sr_value;                              // RULE9 RULE15
        end else if (i_output_clock_enable) begin                  // RULE8 RULE12
          next_oreg_first = i_output_data_first;                   // RULE13
        end
      end
      if (rise_o2 && is_ddr) begin
        if (sr_sync) begin
          next_oreg_second = sr_value;                             // RULE15
        end else if (i_output_clock_enable) begin                  // RULE12
          next_oreg_second = i_output_data_second;                 // RULE14
        end
      end
    end
    // First clock wins if both rise together; they should alternate
    if (rise_o1) begin
      next_last_second = 1'b0;                                     // RULE17
    end else if (rise_o2 && is_ddr) begin
      next_last_second = 1'b1;                                     // RULE17
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oreg_first  <= `IOC_RST_CAPTURE;
      oreg_second <= `IOC_RST_CAPTURE;
      olatch      <= `IOC_RST_CAPTURE;
      last_second <= `IOC_RST_SEL;
    end else begin
      oreg_first  <= next_oreg_first;
      oreg_second <= next_oreg_second;
      olatch      <= next_olatch;
      last_second <= next_last_second;
    end
  end

  // ------------------------------------------------------------------
  // Pad driver: registered so the pin toggles cleanly, at the cost of
  // one system cycle of latency in direct mode; other modes add none
  // ------------------------------------------------------------------
  logic next_pad;
  logic next_pad_oe;

  always_comb begin
    next_pad_oe = 1'b1;
    case (i_cfg.out_mode)
      IOC_OUT_DIRECT: begin
        next_pad = i_output_data_first;                            // RULE7
      end
      IOC_OUT_LATCH: begin
        next_pad = next_olatch;                                    // RULE7
      end
      IOC_OUT_SDR: begin
        next_pad = next_oreg_first;                                // RULE8 RULE9
      end
      IOC_OUT_DDR: begin
        next_pad = next_last_second ? next_oreg_second
                                    : next_oreg_first;             // RULE17
      end
      default: begin
        next_pad = next_oreg_first;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pad    <= `IOC_RST_PAD;
      o_pad_oe <= `IOC_RST_PAD_OE;
    end else begin
      o_pad    <= next_pad;
      o_pad_oe <= next_pad_oe;
    end
  end

endmodule : ioc_io_cell

// ===== sim/ioc_board_model.sv
`timescale 1ns/10ps

module ioc_board_model (
  input  wire logic i_drive_en,
  input  wire logic i_drive_val,
  input  wire logic i_cell_out,
  input  wire logic i_cell_oe,
  output logic      o_line
);
  // The board driver wins, so capture tests need not wait for a release.
  // A line that nobody drives sits at the pull-up level.
  assign o_line = i_drive_en ? i_drive_val : (i_cell_oe ? i_cell_out : 1'h1);
endmodule : ioc_board_model

// ===== sim/ioc_io_cell_assertions.sv
`timescale 1ns/10ps

module ioc_io_cell_checker
  import ioc_pkg::*;
(
  input wire logic     i_clk_sys,
  input wire logic     i_reset_n,
  input wire ioc_cfg_s i_cfg,
  input wire logic     i_pad,
  input wire logic     o_pad,
  input wire logic     i_input_clock_first,
  input wire logic     i_input_clock_second,
  input wire logic     i_input_clock_enable,
  input wire logic     o_input_capture_first,
  input wire logic     o_input_capture_second,
  input wire logic     o_input_capture_out,
  input wire logic     i_output_clock_first,
  input wire logic     i_output_clock_second,
  input wire logic     i_output_clock_enable,
  input wire logic     i_output_data_first,
  input wire logic     i_output_data_second,
  input wire logic     i_local_set_reset,
  input wire logic     i_global_set_reset
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic pad_q, d1_q, d2_q, calm, ok_in, ok_sr, ok_o1, ok_o2;
  always_ff @(posedge i_clk_sys) begin
    pad_q <= i_pad;
    d1_q  <= i_output_data_first;
    d2_q  <= i_output_data_second;
  end
  assign calm  = !i_local_set_reset && !i_global_set_reset;
  assign ok_in = calm && i_input_clock_enable && (i_pad == pad_q);
  assign ok_sr = i_local_set_reset && !i_cfg.sr_async && !i_global_set_reset;
  assign ok_o1 = calm && i_output_clock_enable && (d1_q == i_output_data_first)
                 && (i_cfg.out_mode == IOC_OUT_SDR);
  assign ok_o2 = calm && i_output_clock_enable && (d2_q == i_output_data_second)
                 && (i_cfg.out_mode == IOC_OUT_DDR);
  // A detected pin clock rise loads the register three or four edges later
  sequence s_rise(c, ok);
    ok[*3] ##0 $rose(c) ##1 ok[*2];
  endsequence
  property p_load(c, ok, q, d);
    s_rise(c, ok) |-> ##[1:2] (q == d);
  endproperty
  a_ice_low_hold: assert property (
    (!i_input_clock_enable && calm)[*5] |->
      $stable(o_input_capture_first) && $stable(o_input_capture_second))
    else $error("capture changed while its enable was low");
  a_cap_first_load: assert property (
    p_load(i_input_clock_first, ok_in, o_input_capture_first, i_pad))
    else $error("first capture missed the pad value");
  a_cap_second_load: assert property (
    p_load(i_input_clock_second, ok_in && i_cfg.in_ddr,
           o_input_capture_second, i_pad))
    else $error("second capture missed the pad value");
  a_cap_out_view: assert property (
    o_input_capture_out == o_input_capture_first)
    else $error("single-rate view differs from first capture");
  a_sync_sr_cap: assert property (
    p_load(i_input_clock_first, ok_sr, o_input_capture_first, i_cfg.sr_set))
    else $error("synchronous set/reset missed first capture");
  a_oce_low_hold: assert property (
    (!i_output_clock_enable && calm && i_cfg.out_mode == IOC_OUT_SDR)[*5]
      |-> $stable(o_pad))
    else $error("pad changed while output enable was low");
  a_sdr_out_load: assert property (
    p_load(i_output_clock_first, ok_o1, o_pad, i_output_data_first))
    else $error("output register missed its data");
  a_ddr_second_load: assert property (
    p_load(i_output_clock_second, ok_o2, o_pad, i_output_data_second))
    else $error("pad does not show second output register");
  a_direct_path: assert property (
    (i_cfg.out_mode == IOC_OUT_DIRECT)[*2] |->
      o_pad == $past(i_output_data_first))
    else $error("direct pad does not follow data");
  a_async_force: assert property (
    (i_local_set_reset && i_cfg.sr_async &&
     i_cfg.out_mode != IOC_OUT_DIRECT)[*2] |-> o_pad == i_cfg.sr_set)
    else $error("asynchronous set/reset did not force pad");
  a_global_force: assert property (
    (i_global_set_reset && i_cfg.out_mode != IOC_OUT_DIRECT)[*2] |->
      o_pad == i_cfg.sr_set && o_input_capture_first == i_cfg.sr_set)
    else $error("global set/reset did not force registers");
endmodule : ioc_io_cell_checker

bind ioc_io_cell ioc_io_cell_checker u_checker (.*);

// ===== sim/ioc_io_cell_tb_top.sv
`timescale 1ns/10ps

module ioc_io_cell_tb_top
  import ioc_pkg::*;
;
  logic i_clk_sys = 0, i_reset_n = 0, i_input_clock_enable = 0;
  logic i_input_clock_first = 0, i_input_clock_second = 0;
  logic i_output_clock_first = 0, i_output_clock_second = 0;
  logic i_output_clock_enable = 0, i_local_set_reset = 0;
  logic i_output_data_first = 0, i_output_data_second = 0;
  logic i_global_set_reset = 0, bd_en = 0, bd_val = 0;
  ioc_cfg_s i_cfg = '{IOC_OUT_SDR, 1'h0, 1'h0, 1'h1};
  logic i_pad, o_pad, o_pad_oe;
  logic o_input_capture_first, o_input_capture_second, o_input_capture_out;
  int err_total = 0, comparisons = 0;

  ioc_io_cell dut (.*);
  ioc_board_model u_board (.i_drive_en(bd_en), .i_drive_val(bd_val),
    .i_cell_out(o_pad), .i_cell_oe(o_pad_oe), .o_line(i_pad));

  always #5 i_clk_sys = ~i_clk_sys;

  task automatic end_sim;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : cyc

  // Pin clocks are held four system cycles per phase so they are seen
  task automatic pulse(ref logic c);
    c = 1'h1;
    cyc(4);
    c = 1'h0;
    cyc(4);
  endtask : pulse

  task automatic t_in_ddr;
    bd_en = 1'h1;
    bd_val = 1'h1;
    i_input_clock_enable = 1'h1;
    cyc(3);
    pulse(i_input_clock_first);
    chk(o_input_capture_first, 1'h1);
    chk(o_input_capture_out, 1'h1);
    chk(o_input_capture_second, 1'h0);
    pulse(i_input_clock_second);
    chk(o_input_capture_second, 1'h1);
    i_input_clock_enable = 1'h0;
    bd_val = 1'h0;
    cyc(3);
    pulse(i_input_clock_first);
    pulse(i_input_clock_second);
    chk(o_input_capture_first, 1'h1);
    chk(o_input_capture_second, 1'h1);
  endtask : t_in_ddr

  task automatic t_in_sr;
    bd_val = 1'h1;
    i_input_clock_enable = 1'h1;
    i_local_set_reset = 1'h1;
    cyc(3);
    pulse(i_input_clock_first);
    chk(o_input_capture_first, 1'h0);
    chk(o_input_capture_second, 1'h1);
    pulse(i_input_clock_second);
    chk(o_input_capture_second, 1'h0);
    i_local_set_reset = 1'h0;
    i_cfg.in_ddr = 1'h0;
    cyc(3);
    pulse(i_input_clock_second);
    chk(o_input_capture_second, 1'h0);
    i_cfg.in_ddr = 1'h1;
    bd_en = 1'h0;
  endtask : t_in_sr

  task automatic t_out_sdr;
    i_output_clock_enable = 1'h1;
    i_output_data_first = 1'h1;
    cyc(3);
    pulse(i_output_clock_first);
    chk(o_pad, 1'h1);
    i_output_clock_enable = 1'h0;
    i_output_data_first = 1'h0;
    cyc(3);
    pulse(i_output_clock_first);
    chk(o_pad, 1'h1);
    i_local_set_reset = 1'h1;
    cyc(3);
    chk(o_pad, 1'h1);
    pulse(i_output_clock_first);
    chk(o_pad, 1'h0);
    i_local_set_reset = 1'h0;
  endtask : t_out_sdr

  task automatic t_force;
    i_cfg.sr_async = 1'h1;
    i_cfg.sr_set = 1'h1;
    i_local_set_reset = 1'h1;
    cyc(2);
    chk(o_pad, 1'h1);
    i_local_set_reset = 1'h0;
    i_cfg.sr_async = 1'h0;
    i_cfg.sr_set = 1'h0;
    i_global_set_reset = 1'h1;
    cyc(2);
    chk(o_pad, 1'h0);
    i_global_set_reset = 1'h0;
  endtask : t_force

  task automatic t_out_ddr;
    i_cfg.out_mode = IOC_OUT_DDR;
    i_output_clock_enable = 1'h1;
    i_output_data_first = 1'h1;
    i_output_data_second = 1'h0;
    cyc(3);
    pulse(i_output_clock_first);
    chk(o_pad, 1'h1);
    pulse(i_output_clock_second);
    chk(o_pad, 1'h0);
    i_cfg.sr_set = 1'h1;
    i_local_set_reset = 1'h1;
    cyc(3);
    pulse(i_output_clock_first);
    chk(o_pad, 1'h1);
    pulse(i_output_clock_second);
    chk(o_pad, 1'h1);
    i_local_set_reset = 1'h0;
  endtask : t_out_ddr

  task automatic t_direct_latch;
    i_cfg.out_mode = IOC_OUT_DIRECT;
    cyc(2);
    chk(o_pad, 1'h1);
    i_output_data_first = 1'h0;
    cyc(2);
    chk(o_pad, 1'h0);
    i_cfg.out_mode = IOC_OUT_LATCH;
    i_output_clock_first = 1'h1;
    i_output_data_first = 1'h1;
    cyc(4);
    chk(o_pad, 1'h1);
    i_output_clock_first = 1'h0;
    cyc(4);
    i_output_data_first = 1'h0;
    cyc(4);
    chk(o_pad, 1'h1);
  endtask : t_direct_latch

  initial begin
    repeat (2000) @(posedge i_clk_sys);
    err_total++;
    end_sim();
  end

  initial begin
    cyc(6);
    i_reset_n = 1'h1;
    cyc(3);
    chk(o_pad_oe, 1'h1);
    t_in_ddr();
    t_in_sr();
    t_out_sdr();
    t_force();
    t_out_ddr();
    t_direct_latch();
    end_sim();
  end
endmodule : ioc_io_cell_tb_top
